// >>> rtl/bert_rx_counters_status.sv
// receive bert counters, latched status flags and apb register port
`timescale 1ns/1ps
`include "bert_rx_consts.svh"

module bert_rx_counters_status (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire bert_rx_pkg::apb_addr_t paddr,
  input  wire bert_rx_pkg::word_t pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output bert_rx_pkg::word_t      prdata,
  output logic                    pslverr,
  input  wire logic               bit_strobe,
  input  wire logic               bit_value,
  input  wire logic               bit_mismatch,
  input  wire logic               checker_searching,
  output logic                    irq
);
  import bert_rx_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]        control_q;
  logic              load_prev_q;
  logic              load_pulse;
  logic [31:0]       live_bits_q;
  logic [23:0]       live_errs_q;
  logic [31:0]       snap_bits_q;
  logic [23:0]       snap_errs_q;
  flags_t            status_q;
  flags_t            status_d;
  flags_t            mask_q;
  flags_t            set_vec;
  flags_t            clr_vec;
  logic [3:0]        cond_now;
  logic [3:0]        cond_q;
  logic              ones_run;
  logic              zeros_run;
  logic              match_run;
  logic              in_sync;
  logic              err_event;
  logic              bit_ovf;
  logic              err_ovf;
  logic              setup;
  logic              wr_access;
  reg_index_t        idx;
  logic              aligned;
  logic [7:0]        rd_byte;
  logic              rd_hit;
  word_t             prdata_q;
  logic              pslverr_q;

  // byte address to register index
  function automatic reg_index_t word_index(input apb_addr_t a);
    word_index = a[15:2];
  endfunction : word_index

  //////////////////////////////////////////////////////////////////////////
  // apb decode

  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite & pstrb[0] & aligned;
  assign idx       = word_index(paddr);
  assign aligned   = (paddr[1:0] == 2'b00);
  // zero wait states; data was captured during the setup cycle
  assign pready    = 1'b1;

  // read mux; narrow registers sit in the low byte
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = aligned;
    if (idx == `IDX_CONTROL) begin
      rd_byte = control_q;
    // bit count bytes, counter bit 0 first
    end else if (idx == `IDX_BIT_COUNT_0) begin
      rd_byte = snap_bits_q[7:0];
    end else if (idx == `IDX_BIT_COUNT_1) begin
      rd_byte = snap_bits_q[15:8];
    end else if (idx == `IDX_BIT_COUNT_2) begin
      rd_byte = snap_bits_q[23:16];
    end else if (idx == `IDX_BIT_COUNT_3) begin
      rd_byte = snap_bits_q[31:24];
    end else if (idx == `IDX_ERR_COUNT_0) begin
      rd_byte = snap_errs_q[7:0];
    end else if (idx == `IDX_ERR_COUNT_1) begin
      rd_byte = snap_errs_q[15:8];
    end else if (idx == `IDX_ERR_COUNT_2) begin
      rd_byte = snap_errs_q[23:16];
    end else if (idx == `IDX_STATUS) begin
      rd_byte = {1'b0, status_q};
    end else if (idx == `IDX_MASK) begin
      rd_byte = {1'b0, mask_q};
    end else begin
      rd_hit  = 1'b0;
    end
  end

  // read data and error flag registered in setup, shown in access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_q <= ~rd_hit;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////
  // control and load pulse

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_q <= `CTL_RESET;
    end else if (wr_access && idx == `IDX_CONTROL) begin
      control_q <= pwdata[7:0];
    end
  end

  // rising edge only; software must drop the bit to reload
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_prev_q <= 1'b0;
    end else begin
      load_prev_q <= control_q[`CTL_LOAD_BIT];
    end
  end

  assign load_pulse = control_q[`CTL_LOAD_BIT] & ~load_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // condition detectors

  bert_run_detect u_ones (
    .clk     (clk),
    .rstn    (rstn),
    .step    (bit_strobe),
    .hit     (bit_value),
    .restart (1'b0),
    .reached (ones_run)
  );

  bert_run_detect u_zeros (
    .clk     (clk),
    .rstn    (rstn),
    .step    (bit_strobe),
    .hit     (~bit_value),
    .restart (1'b0),
    .reached (zeros_run)
  );

  // 32 matching positions; a new search restarts the run
  bert_run_detect u_match (
    .clk     (clk),
    .rstn    (rstn),
    .step    (bit_strobe),
    .hit     (~bit_mismatch),
    .restart (checker_searching),
    .reached (match_run)
  );

  assign in_sync  = match_run & ~checker_searching;
  assign cond_now = {ones_run, zeros_run, checker_searching, in_sync};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cond_q <= 4'h0;
    end else begin
      cond_q <= cond_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // live counters and snapshot

  // mismatches only count as errors while in sync
  assign err_event = bit_strobe & bit_mismatch & in_sync;
  // wrap of the live bit counter
  assign bit_ovf   = bit_strobe & (&live_bits_q);
  // wrap of the live error counter
  assign err_ovf   = err_event & (&live_errs_q);

  // a bit arriving with the load starts the new period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      live_bits_q <= 32'h0000_0000;
      live_errs_q <= 24'h00_0000;
    end else if (load_pulse) begin
      live_bits_q <= {31'h0, bit_strobe};
      live_errs_q <= {23'h0, err_event};
    end else begin
      live_bits_q <= live_bits_q + {31'h0, bit_strobe};
      live_errs_q <= live_errs_q + {23'h0, err_event};
    end
  end

  // copy live counts out on load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snap_bits_q <= 32'h0000_0000;
      snap_errs_q <= 24'h00_0000;
    end else if (load_pulse) begin
      snap_bits_q <= live_bits_q;
      snap_errs_q <= live_errs_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // latched status, mask and interrupt

  // both edges of each condition set its flag
  assign set_vec[3:0]             = cond_now ^ cond_q;
  assign set_vec[`ST_ERROR_DETECT] = err_event;
  assign set_vec[`ST_BITCNT_OVF]  = bit_ovf;
  assign set_vec[`ST_ERRCNT_OVF]  = err_ovf;

  // write data bit 7 reaches no status or mask flop
  assign clr_vec = (wr_access && idx == `IDX_STATUS) ? pwdata[6:0] : 7'h00;

  // write one to clear; a set in the same cycle wins
  // every flag latches the same way
  assign status_d = (status_q & ~clr_vec) | set_vec;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= `ST_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= `MASK_RESET;
    end else if (wr_access && idx == `IDX_MASK) begin
      mask_q <= pwdata[6:0];
    end
  end

  // a one in the mask lets its flag through
  assign irq = |(status_q & mask_q);

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_read_setup(logic [13:0] i);
    setup && !pwrite && aligned && idx == i;
  endsequence

  sequence s_no_clear(int b);
    !(wr_access && idx == `IDX_STATUS && pwdata[b]);
  endsequence

  a_bit_top_byte: assert property (
    s_read_setup(`IDX_BIT_COUNT_3) |=>
      prdata == {24'h0, $past(snap_bits_q[31:24])})
    else $error("bit count top byte wrong");

  a_bit_low_byte: assert property (
    s_read_setup(`IDX_BIT_COUNT_0) |=>
      prdata[7:0] == $past(snap_bits_q[7:0]))
    else $error("bit count low byte wrong");

  a_err_low_byte: assert property (
    s_read_setup(`IDX_ERR_COUNT_0) |=>
      prdata[7:0] == $past(snap_errs_q[7:0]))
    else $error("error count low byte wrong");

  a_err_mid_byte: assert property (
    s_read_setup(14'h110c) |=>
      prdata[7:0] == $past(snap_errs_q[15:8]) && !pslverr)
    else $error("error count middle byte wrong");

  a_error_out_sync: assert property (
    bit_strobe && bit_mismatch && !in_sync && !load_pulse |=>
      live_errs_q == $past(live_errs_q) && !status_q[6] ||
      $past(status_q[6]))
    else $error("error counted while out of sync");

  a_error_flag: assert property (
    err_event |=> status_q[`ST_ERROR_DETECT])
    else $error("error flag not latched");

  a_bit_overflow: assert property (
    bit_strobe && live_bits_q == 32'hffff_ffff && !load_pulse |=>
      status_q[`ST_BITCNT_OVF] && live_bits_q == 32'h0)
    else $error("bit counter overflow not flagged");

  a_err_overflow: assert property (
    err_event && live_errs_q == 24'hff_ffff |=>
      status_q[`ST_ERRCNT_OVF])
    else $error("error counter overflow not flagged");

  a_ones_edge: assert property (
    $changed(ones_run) |-> ##0 status_d[`ST_ALL_ONES] ##1
      status_q[`ST_ALL_ONES])
    else $error("all ones change not latched");

  a_zeros_edge: assert property (
    $changed(zeros_run) |=> status_q[`ST_ALL_ZEROS])
    else $error("all zeros change not latched");

  a_lost_flag: assert property (
    $rose(checker_searching) |=> status_q[`ST_SYNC_LOST] && !in_sync)
    else $error("search start not latched");

  a_sync_flag: assert property (
    $rose(in_sync) |-> ##0 match_run ##1 status_q[`ST_IN_SYNC])
    else $error("sync gain not latched");

  a_load_copy: assert property (
    load_pulse |=> snap_bits_q == $past(live_bits_q) &&
      snap_errs_q == $past(live_errs_q) &&
      live_bits_q <= 32'h1)
    else $error("load did not copy and clear");

  a_flag_sticky: assert property (
    status_q[6] and s_no_clear(6) |=> status_q[6])
    else $error("flag dropped without clear");

  a_mask_blocks: assert property (
    !irq == ((status_q & mask_q) == 7'h00))
    else $error("mask gating wrong");

  a_unused_bit7: assert property (
    s_read_setup(`IDX_STATUS) or s_read_setup(`IDX_MASK) |=>
      prdata[7] == 1'b0)
    else $error("bit 7 not zero");

endmodule : bert_rx_counters_status

// >>> rtl/bert_rx_consts.svh
// register map, field positions and counts for the receive bert result logic
`ifndef BERT_RX_CONSTS_SVH
`define BERT_RX_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_CONTROL      14'h1105
`define IDX_BIT_COUNT_0  14'h1107
`define IDX_BIT_COUNT_1  14'h1108
`define IDX_BIT_COUNT_2  14'h1109
`define IDX_BIT_COUNT_3  14'h110a
`define IDX_ERR_COUNT_0  14'h110b
`define IDX_ERR_COUNT_1  14'h110c
`define IDX_ERR_COUNT_2  14'h110d
`define IDX_STATUS       14'h110e
`define IDX_MASK         14'h110f

// control register fields
`define CTL_LOAD_BIT     1
`define CTL_RESET        8'h00

// status and mask bit positions
`define ST_ERROR_DETECT  6
`define ST_BITCNT_OVF    5
`define ST_ERRCNT_OVF    4
`define ST_ALL_ONES      3
`define ST_ALL_ZEROS     2
`define ST_SYNC_LOST     1
`define ST_IN_SYNC       0
`define ST_USED_MASK     8'h7f
`define ST_RESET         7'h00
`define MASK_RESET       7'h00

// counter widths and run length
`define BIT_COUNT_W      32
`define ERR_COUNT_W      24
`define RUN_LENGTH       6'd32

`endif

// >>> rtl/bert_rx_pkg.sv
// types shared by the receive bert result logic
package bert_rx_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] apb_addr_t;
  typedef logic [13:0] reg_index_t;
  typedef logic [6:0]  flags_t;
endpackage : bert_rx_pkg

// >>> rtl/bert_run_detect.sv
// saturating run-length detector for a repeated bit condition
`timescale 1ns/1ps
`include "bert_rx_consts.svh"

module bert_run_detect (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic step,
  input  wire logic hit,
  input  wire logic restart,
  output logic      reached
);
  logic [5:0] run_q;
  logic [5:0] run_d;

  // count consecutive hits, stop at the run length, miss restarts
  always_comb begin
    run_d = run_q;
    if (restart) begin
      run_d = 6'h00;
    end else if (step) begin
      if (!hit) begin
        run_d = 6'h00;
      end else if (run_q != `RUN_LENGTH) begin
        run_d = run_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= 6'h00;
    end else begin
      run_q <= run_d;
    end
  end

  // level from a flop, so edges of it are clean
  assign reached = (run_q == `RUN_LENGTH);

endmodule : bert_run_detect

// >>> tb/tb_top.sv
// self-checking bench for the receive bert counters and status block
`timescale 1ns/1ps
`include "bert_rx_consts.svh"

module tb_top;
  import bert_rx_pkg::*;

  // one compare: counted, x never passes
  `define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("mismatch t=%0t got %h exp %h", $time, g, e); \
    end \
  end
  `define AD(i) {i, 2'b00}

  logic      clk = 1'b0;
  logic      rstn;
  logic      psel;
  logic      penable;
  logic      pwrite;
  apb_addr_t paddr;
  word_t     pwdata;
  logic [3:0] pstrb;
  logic      pready;
  word_t     prdata;
  logic      pslverr;
  logic      bit_strobe;
  logic      bit_value;
  logic      bit_mismatch;
  logic      checker_searching;
  logic      irq;
  word_t     rd;
  logic      err;
  logic      tog = 1'b0;
  int        fail_count = 0;
  int        compares = 0;

  bert_rx_counters_status u_dut (
    .clk               (clk),
    .rstn              (rstn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pstrb             (pstrb),
    .pready            (pready),
    .prdata            (prdata),
    .pslverr           (pslverr),
    .bit_strobe        (bit_strobe),
    .bit_value         (bit_value),
    .bit_mismatch      (bit_mismatch),
    .checker_searching (checker_searching),
    .irq               (irq)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task summarize;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // one apb transfer; request held until pready is seen high
  // no local limit: only the watchdog ends a hung wait
  task apb(input apb_addr_t a, input logic wrt, input word_t wd,
           input logic [3:0] st);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wrt;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input reg_index_t i, input word_t d);
    apb(`AD(i), 1'b1, d, 4'h1);
  endtask : wr

  task rdr(input reg_index_t i);
    apb(`AD(i), 1'b0, 32'h0, 4'h0);
  endtask : rdr

  // n received bits; kind 2 alternates so no run builds up
  task send(input int n, input logic [1:0] kind, input logic mm);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      bit_strobe   <= 1'b1;
      bit_value    <= kind[1] ? tog : kind[0];
      bit_mismatch <= mm;
      tog = ~tog;
    end
    @(posedge clk);
    bit_strobe   <= 1'b0;
    bit_mismatch <= 1'b0;
  endtask : send

  // irq looked at one cycle after the write that changes it
  task irq_is(input logic e);
    @(posedge clk);
    `CHK(irq, e)
  endtask : irq_is

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the run needs about 10k cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    summarize();
  end

  // main sequence
  initial begin
    rstn              = 1'b0;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 16'h0;
    pwdata            = 32'h0;
    pstrb             = 4'h0;
    bit_strobe        = 1'b0;
    bit_value         = 1'b0;
    bit_mismatch      = 1'b0;
    checker_searching = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // every mapped byte from the count bytes to the mask reads zero
    for (int i = 0; i < 9; i++) begin
      rdr(reg_index_t'(`IDX_BIT_COUNT_0 + i));
      `CHK({err, rd}, 33'h0)
    end
    // count bytes are read-only, mask bit 7 is unused
    wr(`IDX_ERR_COUNT_0, 32'hff);
    rdr(`IDX_ERR_COUNT_0);
    `CHK({err, rd}, 33'h0)
    wr(`IDX_MASK, 32'hff);
    rdr(`IDX_MASK);
    `CHK(rd, 32'h7f)
    apb(`AD(`IDX_MASK), 1'b1, 32'h0, 4'h0);
    rdr(`IDX_MASK);
    `CHK(rd, 32'h7f)
    wr(`IDX_MASK, 32'h0);
    rdr(14'h1000);
    `CHK({err, rd}, 33'h1_0000_0000)
    // loss of sync on both changes; no errors while searching
    checker_searching <= 1'b1;
    send(3, 2'd2, 1'b1);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h42, 8'h02)
    wr(`IDX_STATUS, 32'h7f);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h02, 8'h00)
    checker_searching <= 1'b0;
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h02, 8'h02)
    // sync needs exactly 32 matching positions
    send(31, 2'd2, 1'b0);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h01, 8'h00)
    send(1, 2'd2, 1'b0);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h01, 8'h01)
    send(1, 2'd2, 1'b1);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h40, 8'h40)
    // 261 errors, each preceded by a resync run: 8616 bits in total
    for (int k = 0; k < 260; k++) begin
      send(32, 2'd2, 1'b0);
      send(1, 2'd2, 1'b1);
    end
    wr(`IDX_CONTROL, 32'h02);
    for (int j = 0; j < 4; j++) begin
      rdr(reg_index_t'(`IDX_BIT_COUNT_0 + j));
      `CHK(rd, (32'h21a8 >> (8 * j)) & 32'hff)
    end
    for (int j = 0; j < 3; j++) begin
      rdr(reg_index_t'(`IDX_ERR_COUNT_0 + j));
      `CHK(rd, (32'h105 >> (8 * j)) & 32'hff)
    end
    // second load with no traffic: live counts were cleared
    wr(`IDX_CONTROL, 32'h00);
    wr(`IDX_CONTROL, 32'h02);
    rdr(`IDX_ERR_COUNT_1);
    `CHK(rd, 32'h0)
    rdr(`IDX_BIT_COUNT_0);
    `CHK(rd, 32'h0)
    // all-ones run after a zero, then mask gating of irq
    send(1, 2'd0, 1'b0);
    wr(`IDX_STATUS, 32'h7f);
    send(31, 2'd1, 1'b0);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h08, 8'h00)
    send(1, 2'd1, 1'b0);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h08, 8'h08)
    irq_is(1'b0);
    wr(`IDX_MASK, 32'h08);
    irq_is(1'b1);
    wr(`IDX_STATUS, 32'h08);
    irq_is(1'b0);
    wr(`IDX_MASK, 32'h0);
    // a zero ends the ones run; 32 zeros make the zeros flag
    send(1, 2'd0, 1'b0);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h08, 8'h08)
    send(30, 2'd0, 1'b0);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h04, 8'h00)
    send(1, 2'd0, 1'b0);
    rdr(`IDX_STATUS);
    `CHK(rd[7:0] & 8'h04, 8'h04)
    summarize();
  end
endmodule : tb_top
